//--- hdl/hbv_pkg.sv
// Shared constants and carrier types for the brake and audio-to-vibe block.
// Assumes an 8-bit register port driven by the serial control front end.
package hbv_pkg;
  // Register offsets.
  localparam logic [7:0] HBV_OFS_BRAKE = 8'h10;
  localparam logic [7:0] HBV_OFS_CTRL = 8'h11;
  localparam logic [7:0] HBV_OFS_IN_FLOOR = 8'h12;
  localparam logic [7:0] HBV_OFS_IN_FS = 8'h13;
  localparam logic [7:0] HBV_OFS_DR_FLOOR = 8'h14;
  localparam logic [7:0] HBV_OFS_DR_CEIL = 8'h15;
  // Control field positions.
  localparam int HBV_CTRL_PEAK_LSB = 2;
  localparam int HBV_CTRL_LP_LSB = 0;
  // Reset values.
  localparam logic [7:0] HBV_BRAKE_RST = 8'h00;
  localparam logic [1:0] HBV_PEAK_SEL_RST = 2'h0;
  localparam logic [1:0] HBV_LP_SEL_RST = 2'h1;
  localparam logic [7:0] HBV_IN_FLOOR_RST = 8'h19;
  localparam logic [7:0] HBV_IN_FS_RST = 8'hFF;
  localparam logic [7:0] HBV_DR_FLOOR_RST = 8'h19;
  localparam logic [7:0] HBV_DR_CEIL_RST = 8'hFF;
  // Timing: the peak window is a multiple of 10 ms.
  localparam int HBV_CLK_HZ = 25_000_000;
  localparam int HBV_PEAK_UNIT_MS = 10;
  localparam int HBV_PEAK_UNIT_CYC = HBV_PEAK_UNIT_MS * (HBV_CLK_HZ / 1000);
  localparam int HBV_DIV_STEPS = 16;

  typedef struct packed {
    logic [7:0] brake;
    logic [1:0] peak_sel;
    logic [1:0] lp_sel;
    logic [7:0] in_floor;
    logic [7:0] in_fs;
    logic [7:0] dr_floor;
    logic [7:0] dr_ceil;
  } hbv_cfg_s;

  typedef struct packed {
    logic valid;
    logic signed [7:0] level;
    logic [7:0] index;
  } hbv_sample_s;
endpackage : hbv_pkg

//--- hdl/hbv_peak_window.sv
// Peak detector over a window of one to four time units.
// Assumes amplitude samples arrive on the same clock.
`timescale 1ns/1ns
`default_nettype none
module hbv_peak_window
  import hbv_pkg::*;
#(
  parameter int UNIT_CYC = HBV_PEAK_UNIT_CYC,
  parameter int CW = 24
) (
  // Clock and reset.
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Control.
  input wire logic enable_in,
  input wire logic [1:0] sel_in,
  // Amplitude stream.
  input wire logic amp_valid_in,
  input wire logic [7:0] amp_in,
  // Result.
  output logic peak_valid_out,
  output logic [7:0] peak_out
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [7:0] maxv;
    logic [7:0] peak;
    logic pv;
  } hbv_pk_state_s;

  hbv_pk_state_s s, next_s;
  logic [CW-1:0] last_cnt;
  logic [7:0] new_max;

  always_comb begin
    last_cnt = CW'((int'(sel_in) + 1) * UNIT_CYC - 1);
    new_max = (amp_valid_in && amp_in > s.maxv) ? amp_in : s.maxv;
    next_s = s;
    next_s.pv = 1'b0;
    if (!enable_in) begin
      next_s.cnt = '0;
      next_s.maxv = 8'h00;
    end else if (s.cnt >= last_cnt) begin
      next_s.cnt = '0;
      next_s.maxv = 8'h00;
      next_s.peak = new_max;
      next_s.pv = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 1'b1;
      next_s.maxv = new_max;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign peak_valid_out = s.pv;
  assign peak_out = s.peak;
endmodule : hbv_peak_window
`default_nettype wire

//--- hdl/hbv_brake_finder.sv
// Finds the sample with the most negative drive value in a waveform.
// Assumes the playback engine streams each waveform between start and end.
`timescale 1ns/1ns
`default_nettype none
module hbv_brake_finder
  import hbv_pkg::*;
(
  // Clock and reset.
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Waveform stream.
  input wire logic start_in,
  input wire hbv_sample_s sample_in,
  input wire logic end_in,
  // Result.
  output logic [7:0] brake_index_out,
  output logic found_out
);
  typedef struct packed {
    logic signed [7:0] minv;
    logic [7:0] idx;
    logic have;
    logic [7:0] brake_index;
    logic found;
  } hbv_bf_state_s;

  hbv_bf_state_s s, next_s;
  logic take;

  always_comb begin
    // Strict compare keeps the first of equal minima.
    take = sample_in.valid && (!s.have || sample_in.level < s.minv);
    next_s = s;
    if (start_in) begin
      next_s.have = 1'b0;
      next_s.found = 1'b0;
    end else begin
      if (take) begin
        next_s.minv = sample_in.level;
        next_s.idx = sample_in.index;
        next_s.have = 1'b1;
      end
      if (end_in) begin
        next_s.brake_index = take ? sample_in.index : s.idx;
        next_s.found = take | s.have;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign brake_index_out = s.brake_index;
  assign found_out = s.found;
endmodule : hbv_brake_finder
`default_nettype wire

//--- hdl/hbv_top.sv
// Brake time adjust and audio-to-vibe configuration with its drive mapping.
// Assumes the serial bus front end, playback engine and input ADC share clock_in.
`timescale 1ns/1ns
`default_nettype none
module hbv_top
  import hbv_pkg::*;
#(
  parameter int PEAK_UNIT_CYC = HBV_PEAK_UNIT_CYC,
  parameter int WP_W = 4
) (
  // Clock and reset.
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Register port.
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Waveform playback.
  input wire logic wave_start_in,
  input wire hbv_sample_s wave_sample_in,
  input wire logic wave_end_in,
  input wire logic open_loop_in,
  input wire logic play_step_valid_in,
  input wire logic [7:0] play_step_index_in,
  input wire logic [WP_W-1:0] waveform_step_period_in,
  output logic [7:0] brake_index_out,
  output logic brake_found_out,
  output logic signed [WP_W+8:0] brake_adjust_ms_out,
  output logic brake_adjust_valid_out,
  // Audio-to-vibe path.
  input wire logic audio_mode_in,
  input wire logic amp_valid_in,
  input wire logic [7:0] amp_in,
  output logic [1:0] lowpass_cutoff_sel_out,
  output logic [7:0] drive_level_out,
  output logic drive_valid_out
);
  localparam int ADJ_W = WP_W + 9;

  typedef struct packed {
    hbv_cfg_s regs;
    logic [7:0] rdata;
    logic rvalid;
    logic signed [ADJ_W-1:0] adj;
    logic adj_valid;
    logic busy;
    logic [4:0] cnt;
    logic [15:0] num;
    logic [8:0] rem;
    logic [15:0] quo;
    logic [7:0] den;
    logic [7:0] cap_floor;
    logic [7:0] cap_ceil;
    logic [7:0] drive;
    logic drive_valid;
  } hbv_top_state_s;

  hbv_top_state_s s, next_s;

  logic peak_valid;
  logic [7:0] peak;
  logic [8:0] rem_sh;
  logic [15:0] quo_sh;
  logic [7:0] span;
  logic [7:0] lvl;

  function automatic logic [7:0] read_mux(input hbv_cfg_s r, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == HBV_OFS_BRAKE) begin
      v = r.brake;
    end else if (a == HBV_OFS_CTRL) begin
      v = {4'h0, r.peak_sel, r.lp_sel};
    end else if (a == HBV_OFS_IN_FLOOR) begin
      v = r.in_floor;
    end else if (a == HBV_OFS_IN_FS) begin
      v = r.in_fs;
    end else if (a == HBV_OFS_DR_FLOOR) begin
      v = r.dr_floor;
    end else if (a == HBV_OFS_DR_CEIL) begin
      v = r.dr_ceil;
    end
    return v;
  endfunction : read_mux

  hbv_brake_finder u_brake (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .start_in(wave_start_in),
    .sample_in(wave_sample_in),
    .end_in(wave_end_in),
    .brake_index_out(brake_index_out),
    .found_out(brake_found_out)
  );

  hbv_peak_window #(
    .UNIT_CYC(PEAK_UNIT_CYC)
  ) u_peak (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .enable_in(audio_mode_in),
    .sel_in(s.regs.peak_sel),
    .amp_valid_in(amp_valid_in),
    .amp_in(amp_in),
    .peak_valid_out(peak_valid),
    .peak_out(peak)
  );

  always_comb begin
    next_s = s;
    next_s.rvalid = 1'b0;
    next_s.adj_valid = 1'b0;
    next_s.drive_valid = 1'b0;
    rem_sh = {s.rem[7:0], s.num[15]};
    quo_sh = {s.quo[14:0], 1'b0};
    span = (s.regs.dr_ceil > s.regs.dr_floor) ? s.regs.dr_ceil - s.regs.dr_floor : 8'h00;
    lvl = 8'h00;

    // Register writes; reserved control bits are dropped.
    if (reg_wr_in) begin
      if (reg_addr_in == HBV_OFS_BRAKE) begin
        next_s.regs.brake = reg_wdata_in;
      end else if (reg_addr_in == HBV_OFS_CTRL) begin
        next_s.regs.peak_sel = reg_wdata_in[HBV_CTRL_PEAK_LSB +: 2];
        next_s.regs.lp_sel = reg_wdata_in[HBV_CTRL_LP_LSB +: 2];
      end else if (reg_addr_in == HBV_OFS_IN_FLOOR) begin
        next_s.regs.in_floor = reg_wdata_in;
      end else if (reg_addr_in == HBV_OFS_IN_FS) begin
        next_s.regs.in_fs = reg_wdata_in;
      end else if (reg_addr_in == HBV_OFS_DR_FLOOR) begin
        next_s.regs.dr_floor = reg_wdata_in;
      end else if (reg_addr_in == HBV_OFS_DR_CEIL) begin
        next_s.regs.dr_ceil = reg_wdata_in;
      end
    end
    if (reg_rd_in) begin
      next_s.rdata = read_mux(s.regs, reg_addr_in);
      next_s.rvalid = 1'b1;
    end

    // Brake step adjustment, answered one cycle after each step request.
    if (play_step_valid_in) begin
      next_s.adj_valid = 1'b1;
      if (open_loop_in && brake_found_out && play_step_index_in == brake_index_out) begin
        next_s.adj = ADJ_W'($signed(s.regs.brake))
          * ADJ_W'($signed({1'b0, waveform_step_period_in}));
      end else begin
        next_s.adj = '0;
      end
    end

    // Drive mapping. A new peak is dropped while a division runs, which
    // cannot happen with windows far longer than the division.
    if (s.busy) begin
      if (rem_sh >= {1'b0, s.den}) begin
        next_s.rem = rem_sh - {1'b0, s.den};
        next_s.quo = quo_sh | 16'h0001;
      end else begin
        next_s.rem = rem_sh;
        next_s.quo = quo_sh;
      end
      next_s.num = {s.num[14:0], 1'b0};
      next_s.cnt = s.cnt - 1'b1;
      if (s.cnt == 5'h01) begin
        lvl = s.cap_floor + next_s.quo[7:0];
        next_s.drive = (lvl > s.cap_ceil) ? s.cap_ceil : lvl;
        next_s.drive_valid = 1'b1;
        next_s.busy = 1'b0;
      end
    end else if (peak_valid) begin
      next_s.cap_floor = s.regs.dr_floor;
      next_s.cap_ceil = s.regs.dr_ceil;
      if (peak < s.regs.in_floor) begin
        next_s.drive = 8'h00;
        next_s.drive_valid = 1'b1;
      end else if (peak >= s.regs.in_fs) begin
        next_s.drive = s.regs.dr_ceil;
        next_s.drive_valid = 1'b1;
      end else begin
        next_s.num = 16'(peak - s.regs.in_floor) * 16'(span);
        next_s.den = s.regs.in_fs - s.regs.in_floor;
        next_s.rem = 9'h000;
        next_s.quo = 16'h0000;
        next_s.cnt = 5'(HBV_DIV_STEPS);
        next_s.busy = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      s <= '0;
      s.regs.brake <= HBV_BRAKE_RST;
      s.regs.peak_sel <= HBV_PEAK_SEL_RST;
      s.regs.lp_sel <= HBV_LP_SEL_RST;
      s.regs.in_floor <= HBV_IN_FLOOR_RST;
      s.regs.in_fs <= HBV_IN_FS_RST;
      s.regs.dr_floor <= HBV_DR_FLOOR_RST;
      s.regs.dr_ceil <= HBV_DR_CEIL_RST;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata_out = s.rdata;
  assign reg_rvalid_out = s.rvalid;
  assign brake_adjust_ms_out = s.adj;
  assign brake_adjust_valid_out = s.adj_valid;
  assign lowpass_cutoff_sel_out = s.regs.lp_sel;
  assign drive_level_out = s.drive;
  assign drive_valid_out = s.drive_valid;

  AST_BRAKE_CLOSED_ZERO:
  assert property (@(posedge clock_in) disable iff (sys_rst_in)
    play_step_valid_in && !open_loop_in |=> brake_adjust_valid_out && brake_adjust_ms_out == 0)
    else $error("Closed-loop step got a brake adjustment.");

  AST_BRAKE_PRODUCT:
  assert property (@(posedge clock_in) disable iff (sys_rst_in)
    play_step_valid_in && open_loop_in && brake_found_out
      && play_step_index_in == brake_index_out
    |=> brake_adjust_ms_out == ADJ_W'($signed($past(s.regs.brake))
      * $signed({1'b0, $past(waveform_step_period_in)})))
    else $error("Brake adjustment is not offset times step period.");

  AST_BRAKE_OTHER_STEP:
  assert property (@(posedge clock_in) disable iff (sys_rst_in)
    play_step_valid_in && play_step_index_in != brake_index_out
    |=> brake_adjust_ms_out == 0)
    else $error("Non-braking step got a brake adjustment.");

  AST_CTRL_READBACK:
  assert property (@(posedge clock_in) disable iff (sys_rst_in)
    reg_wr_in && reg_addr_in == HBV_OFS_CTRL ##1 reg_rd_in && reg_addr_in == HBV_OFS_CTRL
      && !reg_wr_in
    |=> reg_rvalid_out && reg_rdata_out == {4'h0, $past(reg_wdata_in[3:0], 2)})
    else $error("Control readback wrong or reserved bits set.");

  AST_CUTOFF_OUT:
  assert property (@(posedge clock_in) disable iff (sys_rst_in)
    reg_wr_in && reg_addr_in == HBV_OFS_CTRL |=> lowpass_cutoff_sel_out == $past(reg_wdata_in[1:0]))
    else $error("Cutoff select did not follow the write.");

  AST_BELOW_FLOOR:
  assert property (@(posedge clock_in) disable iff (sys_rst_in)
    peak_valid && !s.busy && peak < s.regs.in_floor |=> drive_valid_out && drive_level_out == 8'h00)
    else $error("Peak below input floor was not ignored.");

  AST_FULL_SCALE:
  assert property (@(posedge clock_in) disable iff (sys_rst_in)
    peak_valid && !s.busy && peak >= s.regs.in_fs && peak >= s.regs.in_floor
    |=> drive_valid_out && drive_level_out == $past(s.regs.dr_ceil))
    else $error("Full-scale peak did not give ceiling drive.");

  AST_DRIVE_FLOOR:
  assert property (@(posedge clock_in) disable iff (sys_rst_in)
    drive_valid_out && drive_level_out != 8'h00 && s.cap_floor <= s.cap_ceil
    |-> drive_level_out >= s.cap_floor)
    else $error("Drive below drive floor.");

  AST_DRIVE_CEIL:
  assert property (@(posedge clock_in) disable iff (sys_rst_in)
    drive_valid_out |-> drive_level_out <= s.cap_ceil)
    else $error("Drive above drive ceiling.");

  AST_MAP_LATENCY:
  assert property (@(posedge clock_in) disable iff (sys_rst_in)
    peak_valid && !s.busy && peak >= s.regs.in_floor && peak < s.regs.in_fs
    |-> ##17 drive_valid_out)
    else $error("Mapped drive not produced 17 cycles after the peak.");

  AST_BRAKE_NOT_FOUND:
  assert property (@(posedge clock_in) disable iff (sys_rst_in)
    play_step_valid_in && !brake_found_out |=> brake_adjust_ms_out == 0)
    else $error("Step before any braking sample was found got an adjustment.");

  AST_CUTOFF_RESET:
  assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> lowpass_cutoff_sel_out == HBV_LP_SEL_RST)
    else $error("Cutoff select did not leave reset at its default code.");

  AST_DRIVE_FLOOR_RESET:
  assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> s.regs.dr_floor == HBV_DR_FLOOR_RST)
    else $error("Drive floor did not leave reset at its default code.");
endmodule : hbv_top
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the brake adjust and audio-to-vibe block.
// Assumes the package and the top module are compiled first; one clock only.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import hbv_pkg::*;
  // A short peak unit keeps each window to 30 to 120 cycles.
  localparam int UNIT = 30;
  logic clock_in, sys_rst_in, reg_wr_in, reg_rd_in, reg_rvalid_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, play_step_index_in, amp_in;
  logic wave_start_in, wave_end_in, open_loop_in, play_step_valid_in, audio_mode_in;
  logic amp_valid_in, brake_found_out, brake_adjust_valid_out, drive_valid_out;
  hbv_sample_s wave_sample_in;
  logic [3:0] waveform_step_period_in;
  logic [7:0] brake_index_out, drive_level_out, rv, bi;
  logic signed [12:0] brake_adjust_ms_out;
  logic [1:0] lowpass_cutoff_sel_out;
  logic [7:0] shadow [6];
  int bad_count, cmp_count, cyc, i, j;

  hbv_top #(.PEAK_UNIT_CYC(UNIT), .WP_W(4)) hbv_top_i (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .wave_start_in(wave_start_in), .wave_sample_in(wave_sample_in), .wave_end_in(wave_end_in),
    .open_loop_in(open_loop_in), .play_step_valid_in(play_step_valid_in),
    .play_step_index_in(play_step_index_in), .waveform_step_period_in(waveform_step_period_in),
    .brake_index_out(brake_index_out), .brake_found_out(brake_found_out),
    .brake_adjust_ms_out(brake_adjust_ms_out), .brake_adjust_valid_out(brake_adjust_valid_out),
    .audio_mode_in(audio_mode_in), .amp_valid_in(amp_valid_in), .amp_in(amp_in),
    .lowpass_cutoff_sel_out(lowpass_cutoff_sel_out), .drive_level_out(drive_level_out),
    .drive_valid_out(drive_valid_out)
  );

  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  always @(posedge clock_in) cyc <= cyc + 1;

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  task automatic fail(input string what);
    bad_count++;
    $display("BAD %0t %s", $time, what);
  endtask : fail

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) fail($sformatf("%s got %h expected %h", what, got, exp));
  endtask : chk8

  task automatic chk13(input logic [12:0] got, input logic [12:0] exp);
    cmp_count++;
    if (got !== exp) fail($sformatf("adjust got %0d expected %0d", $signed(got), $signed(exp)));
  endtask : chk13

  task automatic chk_int(input int got, input int exp);
    cmp_count++;
    if (got != exp) fail($sformatf("interval got %0d expected %0d", got, exp));
  endtask : chk_int

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
    if (a >= 8'h10 && a <= 8'h15) shadow[a - 8'h10] = (a == 8'h11) ? (d & 8'h0F) : d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int k;
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    for (k = 0; k < 3; k++) begin
      #1;
      if (reg_rvalid_out === 1'b1) break;
      @(posedge clock_in);
    end
    if (k == 3) fail("no read answer");
    d = reg_rdata_out;
  endtask : rd

  task automatic check_regs();
    int k;
    for (k = 0; k < 6; k++) begin
      rd(8'h10 + 8'(k), rv);
      chk8(rv, shadow[k], "register");
    end
    chk8({6'h0, lowpass_cutoff_sel_out}, {6'h0, shadow[1][1:0]}, "cutoff");
  endtask : check_regs

  function automatic logic signed [12:0] exp_adj(input logic [7:0] off, input logic [3:0] per,
                                                 input bit hit);
    int v;
    v = hit ? $signed(off) * int'(per) : 0;
    return 13'(v);
  endfunction : exp_adj

  function automatic logic [7:0] exp_drive(input int amp);
    int lo, fs, df, dc;
    lo = shadow[2];
    fs = shadow[3];
    df = shadow[4];
    dc = shadow[5];
    if (amp < lo) return 8'h00;
    if (amp >= fs) return 8'(dc);
    return 8'(df + (amp - lo) * (dc - df) / (fs - lo));
  endfunction : exp_drive

  // Ties in the narrow range check that the earliest minimum is kept.
  task automatic send_wave(input int n, input bit narrow, output logic [7:0] mi);
    int k;
    logic signed [7:0] lv, mn;
    mn = 8'sh7F;
    mi = 8'h00;
    @(posedge clock_in);
    wave_start_in <= 1'b1;
    for (k = 0; k < n; k++) begin
      @(posedge clock_in);
      wave_start_in <= 1'b0;
      lv = narrow ? 8'($urandom % 4) - 8'sh02 : 8'($urandom);
      if (lv < mn) begin
        mn = lv;
        mi = 8'(k);
      end
      wave_sample_in <= '{valid: 1'b1, level: lv, index: 8'(k)};
      wave_end_in <= (k == n - 1);
    end
    @(posedge clock_in);
    wave_sample_in.valid <= 1'b0;
    wave_end_in <= 1'b0;
    for (k = 0; k < 3 && brake_found_out !== 1'b1; k++) @(posedge clock_in);
    #1;
    chk8({7'h0, brake_found_out}, 8'h01, "found");
    chk8(brake_index_out, mi, "brake index");
  endtask : send_wave

  task automatic step(input logic [7:0] idx, input logic ol, input bit hit);
    int k;
    @(posedge clock_in);
    open_loop_in <= ol;
    play_step_index_in <= idx;
    play_step_valid_in <= 1'b1;
    @(posedge clock_in);
    play_step_valid_in <= 1'b0;
    for (k = 0; k < 3; k++) begin
      #1;
      if (brake_adjust_valid_out === 1'b1) break;
      @(posedge clock_in);
    end
    if (k == 3) fail("no adjust answer");
    chk13(brake_adjust_ms_out, exp_adj(shadow[0], waveform_step_period_in, hit));
  endtask : step

  // The fourth result comes from a window that saw only the new amplitude.
  task automatic meas(input logic [7:0] a);
    int t [4];
    int k, n;
    @(posedge clock_in);
    amp_in <= a;
    for (n = 0; n < 4; n++) begin
      for (k = 0; k < 400; k++) begin
        @(posedge clock_in);
        #1;
        if (drive_valid_out === 1'b1) break;
      end
      if (k == 400) fail("no drive result");
      t[n] = cyc;
    end
    chk8(drive_level_out, exp_drive(a), "drive");
    chk_int(t[3] - t[2], (int'(shadow[1][3:2]) + 1) * UNIT);
  endtask : meas

  initial begin
    #(40 * 60000);
    fail("watchdog expired");
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h5D29));
    {reg_wr_in, reg_rd_in, wave_start_in, wave_end_in, open_loop_in} = '0;
    {play_step_valid_in, audio_mode_in, amp_valid_in} = '0;
    {reg_addr_in, reg_wdata_in, play_step_index_in, amp_in} = '0;
    wave_sample_in = '0;
    waveform_step_period_in = 4'h0;
    bad_count = 0;
    cmp_count = 0;
    cyc = 0;
    shadow = '{8'h00, 8'h01, 8'h19, 8'hFF, 8'h19, 8'hFF};
    sys_rst_in = 1'b1;
    repeat (20) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    check_regs();
    rd(8'h16, rv);
    chk8(rv, 8'h00, "unmapped");
    wr(8'h0F, 8'hA5);
    for (i = 0; i < 24; i++) wr(8'h10 + 8'($urandom % 6), 8'($urandom));
    for (i = 0; i < 4; i++) begin
      wr(8'h11, {4'hF, 2'(i), 2'(i)});
      check_regs();
    end
    // A read right behind a write to the same register must see the new value.
    @(posedge clock_in);
    reg_addr_in <= 8'h11;
    reg_wdata_in <= 8'hB6;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1;
    shadow[1] = 8'h06;
    chk8({7'h0, reg_rvalid_out}, 8'h01, "back-to-back read answer");
    chk8(reg_rdata_out, shadow[1], "back-to-back control read");
    waveform_step_period_in <= 4'h5;
    wr(8'h10, 8'hFE);
    step(8'h00, 1'b1, 1'b0);
    for (i = 0; i < 8; i++) begin
      waveform_step_period_in <= 4'($urandom);
      wr(8'h10, (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : 8'($urandom));
      send_wave(1 + $urandom % 12, i[0], bi);
      step(bi, 1'b1, 1'b1);
      step(bi, 1'b0, 1'b0);
      step(bi + 8'h01, 1'b1, 1'b0);
    end
    wr(8'h12, 8'h19);
    wr(8'h13, 8'hFF);
    wr(8'h14, 8'h19);
    wr(8'h15, 8'hFF);
    audio_mode_in <= 1'b1;
    amp_valid_in <= 1'b1;
    meas(8'h8C);
    meas(8'h18);
    for (i = 0; i < 4; i++) begin
      j = $urandom % 200;
      wr(8'h11, {4'h0, 2'(i), 2'($urandom)});
      wr(8'h12, 8'(j));
      wr(8'h13, 8'(j + 1 + $urandom % (255 - j)));
      j = $urandom % 256;
      wr(8'h14, 8'(j));
      wr(8'h15, 8'(j + $urandom % (256 - j)));
      if (shadow[2] != 8'h00) meas(shadow[2] - 8'h01);
      meas(shadow[2]);
      meas(shadow[3]);
      meas(8'($urandom));
    end
    // A second reset in mid-run must bring every register back to its default.
    @(posedge clock_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    shadow = '{8'h00, 8'h01, 8'h19, 8'hFF, 8'h19, 8'hFF};
    check_regs();
    chk8({7'h0, brake_found_out}, 8'h00, "found after reset");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
